/* File: design/uabr_top.v */
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uabr_consts.vh"
// Function
// - Break armed after request held past divisor+1
// - Break: start bit then 13xN zero bits
// - Repeat breaks while requested, then stop bits
// - Break sending raises no transmit interrupt
// - 8 or 9 bit words, ninth bit separate
// - Recovery at 16x, shifting per bit
// - Three-sample majority decides each bit
// - Serial data arrives LSB first
// - Word moves to buffer after stop bit
// - Four buffered words, fifth overruns if unread
// - Overrun flags, keeps buffer, interrupts if enabled
// - Receive enable starts start-bit search
// - Data-available flag and fill count readable
// - Interrupt when fill reaches trigger level
// - Status then data read that empties buffer clears available
// - Break received as zero word, framing error
// - After break wait for high line
// - Idle flag low from start to stop
// - Status then data read clears overrun
// - Noise flag set with data, no interrupt
// - Status then data read clears noise
// - Low stop bit sets framing flag
// - Wrong parity bit sets parity flag
module uabr_top (
  input  wire        clk,
  input  wire        rstn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire        rx_pin,
  output reg         tx_pin_ff,
  output reg         rx_irq_ff
);
  localparam RX_IDLE  = 3'd0;
  localparam RX_START = 3'd1;
  localparam RX_DATA  = 3'd2;
  localparam RX_PAR   = 3'd3;
  localparam RX_STOP  = 3'd4;
  localparam RX_BRK   = 3'd5;
  localparam TX_IDLE  = 2'd0;
  localparam TX_START = 2'd1;
  localparam TX_ZERO  = 2'd2;
  localparam TX_STOP  = 2'd3;

  reg  [9:0]  ctrl_ff;
  reg  [15:0] baud_divisor_ff;
  reg         wr_pend_ff;
  reg  [7:0]  wr_addr_ff;
  reg         stat_seen_ff;
  reg         rx_avail_flag_ff;
  reg         overrun_flag_ff;
  reg         noise_flag_ff;
  reg         framing_flag_ff;
  reg         parity_flag_ff;
  reg         rx_idle_flag_ff;
  reg         tx_idle_flag_ff;
  reg  [2:0]  rx_state_ff;
  reg  [3:0]  rx_ph_ff;
  reg  [3:0]  rx_bits_ff;
  reg  [8:0]  rx_shift_reg_ff;
  reg         rx_par_bit_ff;
  reg         vote_a_ff;
  reg         vote_b_ff;
  reg         frame_noise_ff;
  reg  [8:0]  fifo_mem [0:3];
  reg  [1:0]  wr_ptr_ff;
  reg  [1:0]  rd_ptr_ff;
  reg  [2:0]  rx_fill_count_ff;
  reg  [1:0]  tx_state_ff;
  reg  [3:0]  tx_ph_ff;
  reg  [3:0]  tx_cnt_ff;
  reg  [16:0] brk_hold_ff;

  wire        ovs_tick;
  wire        line_level;
  wire        rx_enable_bit      = ctrl_ff[`UABR_CTL_RX_ENABLE_BIT];
  wire        word_length_select = ctrl_ff[`UABR_CTL_LEN9];
  wire        parity_on          = ctrl_ff[`UABR_CTL_PAR_ON];
  wire [1:0]  parity_type_sel    = ctrl_ff[`UABR_CTL_PTYP_HI:`UABR_CTL_PTYP_LO];
  wire        stop2              = ctrl_ff[`UABR_CTL_STOP2];
  wire        break_request_ctl  = ctrl_ff[`UABR_CTL_BREAK];
  wire        rx_int_enable      = ctrl_ff[`UABR_CTL_RIE];
  wire [2:0]  trig_level         = {1'b0, ctrl_ff[`UABR_CTL_TRIG_HI:`UABR_CTL_TRIG_LO]} + 3'd1;

  ////////////////////////////////////////////////////////////////////////////
  // Oversampling front end
  uabr_rx_sampler u_uabr_rx_sampler (
    .clk           (clk),
    .rstn          (rstn),
    .rx_pin        (rx_pin),
    .baud_divisor  (baud_divisor_ff),
    .ovs_tick_ff   (ovs_tick),
    .line_level_ff (line_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; side effects act at the address phase so reads stay zero-wait
  wire        acc        = hsel & htrans[1] & hready;
  wire [7:0]  acc_addr   = haddr[7:0];
  wire        rd_status  = acc & ~hwrite & (acc_addr == `UABR_OFS_STATUS);
  wire        rd_data    = acc & ~hwrite & (acc_addr == `UABR_OFS_DATA);
  wire        pair_done  = rd_data & stat_seen_ff;
  wire [1:0]  rd_slot    = rd_ptr_ff;
  // Empty buffer shows zero, never an unwritten slot
  wire [8:0]  head_word  = (rx_fill_count_ff != 3'd0) ? fifo_mem[rd_slot] : 9'h000;

  wire        vote_bit   = (vote_a_ff & vote_b_ff) | (vote_a_ff & line_level) |
                           (vote_b_ff & line_level);
  wire        vote_noisy = ~((vote_a_ff == vote_b_ff) & (vote_b_ff == line_level));
  wire        at_vote    = ovs_tick & (rx_ph_ff == `UABR_VOTE_C);
  wire        at_bitend  = ovs_tick & (rx_ph_ff == `UABR_OVS_LAST);
  wire        frame_done = at_vote & (rx_state_ff == RX_STOP);
  wire        fifo_full  = (rx_fill_count_ff == `UABR_FIFO_DEPTH);
  wire        push       = frame_done & ~fifo_full;
  wire        overrun    = frame_done & fifo_full;
  wire        pop        = rd_data & (rx_fill_count_ff != 3'd0);
  wire [2:0]  fill_nxt   = rx_fill_count_ff + {2'b00, push} - {2'b00, pop};
  wire [8:0]  word_in    = word_length_select ? rx_shift_reg_ff : {1'b0, rx_shift_reg_ff[8:1]};
  wire        data_par   = ^word_in;
  reg         par_exp;

  always @* begin
    case (parity_type_sel)
      2'b00:   par_exp = data_par;
      2'b01:   par_exp = ~data_par;
      2'b10:   par_exp = 1'b1;
      2'b11:   par_exp = 1'b0;
      default: par_exp = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= acc & hwrite;
      wr_addr_ff <= acc_addr;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      if (acc & ~hwrite) begin
        case (acc_addr)
          `UABR_OFS_STATUS: hrdata <= {24'h00_0000, head_word[8], tx_idle_flag_ff,
                                       rx_idle_flag_ff, parity_flag_ff, framing_flag_ff,
                                       noise_flag_ff, overrun_flag_ff, rx_avail_flag_ff};
          `UABR_OFS_DATA:   hrdata <= {23'h00_0000, head_word};
          `UABR_OFS_CTRL:   hrdata <= {22'h00_0000, ctrl_ff};
          `UABR_OFS_BAUD:   hrdata <= {16'h0000, baud_divisor_ff};
          `UABR_OFS_COUNT:  hrdata <= {29'h0000_0000, rx_fill_count_ff};
          default:          hrdata <= 32'h0000_0000;
        endcase
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      ctrl_ff         <= `UABR_RST_CTRL;
      baud_divisor_ff <= `UABR_RST_BAUD;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == `UABR_OFS_CTRL) ctrl_ff <= hwdata[9:0];
      if (wr_addr_ff == `UABR_OFS_BAUD) baud_divisor_ff <= hwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a new event wins over a same-cycle clear
  always @(posedge clk) begin
    if (!rstn) begin
      stat_seen_ff     <= 1'b0;
      rx_avail_flag_ff <= 1'b0;
      overrun_flag_ff  <= 1'b0;
      noise_flag_ff    <= 1'b0;
      framing_flag_ff  <= 1'b0;
      parity_flag_ff   <= 1'b0;
      rx_irq_ff        <= 1'b0;
    end else begin
      if (rd_status) stat_seen_ff <= 1'b1;
      else if (rd_data) stat_seen_ff <= 1'b0;
      if (push) rx_avail_flag_ff <= 1'b1;
      else if (pair_done & (fill_nxt == 3'd0)) rx_avail_flag_ff <= 1'b0;
      if (overrun) overrun_flag_ff <= 1'b1;
      else if (pair_done) overrun_flag_ff <= 1'b0;
      if (push & (frame_noise_ff | vote_noisy)) noise_flag_ff <= 1'b1;
      else if (pair_done) noise_flag_ff <= 1'b0;
      if (push & ~vote_bit) framing_flag_ff <= 1'b1;
      else if (pair_done) framing_flag_ff <= 1'b0;
      if (push & parity_on & (rx_par_bit_ff != par_exp)) parity_flag_ff <= 1'b1;
      else if (pair_done) parity_flag_ff <= 1'b0;
      // Noise alone never interrupts
      rx_irq_ff <= rx_int_enable & ((push & (fill_nxt == trig_level)) | overrun);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Four-word receive buffer
  always @(posedge clk) begin
    if (!rstn) begin
      wr_ptr_ff        <= 2'b00;
      rd_ptr_ff        <= 2'b00;
      rx_fill_count_ff <= 3'd0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 2'b01;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 2'b01;
      rx_fill_count_ff <= fill_nxt;
    end
  end

  // Overrun discards the fifth word; stored words stay intact
  always @(posedge clk) begin
    if (push) fifo_mem[wr_ptr_ff] <= word_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive frame engine
  always @(posedge clk) begin
    if (!rstn | ~rx_enable_bit) begin
      rx_state_ff     <= RX_IDLE;
      rx_ph_ff        <= 4'h0;
      rx_bits_ff      <= 4'h0;
      rx_shift_reg_ff <= 9'h000;
      rx_par_bit_ff   <= 1'b0;
      vote_a_ff       <= 1'b1;
      vote_b_ff       <= 1'b1;
      frame_noise_ff  <= 1'b0;
      rx_idle_flag_ff <= 1'b1;
    end else begin
      if (ovs_tick) rx_ph_ff <= rx_ph_ff + 4'h1;
      if (ovs_tick & (rx_ph_ff == `UABR_VOTE_A)) vote_a_ff <= line_level;
      if (ovs_tick & (rx_ph_ff == `UABR_VOTE_B)) vote_b_ff <= line_level;
      if (at_vote & (rx_state_ff != RX_IDLE) & (rx_state_ff != RX_BRK) & vote_noisy) begin
        frame_noise_ff <= 1'b1;
      end
      case (rx_state_ff)
        RX_IDLE: begin
          if (~line_level) begin
            rx_state_ff     <= RX_START;
            rx_ph_ff        <= 4'h0;
            rx_bits_ff      <= 4'h0;
            frame_noise_ff  <= 1'b0;
            rx_idle_flag_ff <= 1'b0;
          end
        end
        RX_START: begin
          if (at_vote & vote_bit) begin
            rx_state_ff     <= RX_IDLE;
            rx_idle_flag_ff <= 1'b1;
          end else if (at_bitend) begin
            rx_state_ff <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (at_vote) begin
            rx_shift_reg_ff <= {vote_bit, rx_shift_reg_ff[8:1]};
            rx_bits_ff      <= rx_bits_ff + 4'h1;
          end
          if (at_bitend & (rx_bits_ff == (word_length_select ? 4'd9 : 4'd8))) begin
            rx_state_ff <= parity_on ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          if (at_vote) begin
            rx_par_bit_ff <= vote_bit;
          end
          if (at_bitend) begin
            rx_state_ff <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (at_vote) begin
            rx_idle_flag_ff <= 1'b1;
            rx_state_ff     <= vote_bit ? RX_IDLE : RX_BRK;
          end
        end
        RX_BRK: begin
          // Low line after a break is never a new start bit
          if (line_level) begin
            rx_state_ff <= RX_IDLE;
          end
        end
        default: rx_state_ff <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Break transmitter; no transmit interrupt exists here at all
  wire        brk_armed  = brk_hold_ff > ({1'b0, baud_divisor_ff} + 17'd1);
  wire        tx_bitend  = ovs_tick & (tx_ph_ff == `UABR_OVS_LAST);

  always @(posedge clk) begin
    if (!rstn) begin
      brk_hold_ff <= 17'd0;
    end else if (break_request_ctl & tx_idle_flag_ff) begin
      if (~brk_armed) begin
        brk_hold_ff <= brk_hold_ff + 17'd1;
      end
    end else begin
      brk_hold_ff <= 17'd0;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      tx_state_ff     <= TX_IDLE;
      tx_ph_ff        <= 4'h0;
      tx_cnt_ff       <= 4'h0;
      tx_pin_ff       <= 1'b1;
      tx_idle_flag_ff <= 1'b1;
    end else begin
      if (ovs_tick) tx_ph_ff <= tx_ph_ff + 4'h1;
      case (tx_state_ff)
        TX_IDLE: begin
          tx_pin_ff <= 1'b1;
          if (brk_armed & break_request_ctl & tx_bitend) begin
            tx_state_ff     <= TX_START;
            tx_pin_ff       <= 1'b0;
            tx_idle_flag_ff <= 1'b0;
          end
        end
        TX_START: begin
          if (tx_bitend) begin
            tx_state_ff <= TX_ZERO;
            tx_cnt_ff   <= 4'h0;
          end
        end
        TX_ZERO: begin
          if (tx_bitend) begin
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
            if (tx_cnt_ff == `UABR_BRK_LAST) begin
              tx_cnt_ff <= 4'h0;
              if (~break_request_ctl) begin
                tx_state_ff <= TX_STOP;
                tx_pin_ff   <= 1'b1;
              end
            end
          end
        end
        TX_STOP: begin
          if (tx_bitend) begin
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
            if (tx_cnt_ff == {3'b000, stop2}) begin
              tx_state_ff     <= TX_IDLE;
              tx_idle_flag_ff <= 1'b1;
            end
          end
        end
        default: tx_state_ff <= TX_IDLE;
      endcase
    end
  end
endmodule // uabr_top
`default_nettype wire

/* File: design/uabr_consts.vh */
`ifndef UABR_CONSTS_VH
`define UABR_CONSTS_VH
// Register byte offsets
`define UABR_OFS_STATUS  8'h00
`define UABR_OFS_DATA    8'h04
`define UABR_OFS_CTRL    8'h08
`define UABR_OFS_BAUD    8'h0C
`define UABR_OFS_COUNT   8'h10
// Control field positions
`define UABR_CTL_RX_ENABLE_BIT    0
`define UABR_CTL_LEN9    1
`define UABR_CTL_PAR_ON  2
`define UABR_CTL_PTYP_LO 3
`define UABR_CTL_PTYP_HI 4
`define UABR_CTL_STOP2   5
`define UABR_CTL_BREAK   6
`define UABR_CTL_RIE     7
`define UABR_CTL_TRIG_LO 8
`define UABR_CTL_TRIG_HI 9
// Status field positions
`define UABR_ST_AVAIL    0
`define UABR_ST_OVERRUN  1
`define UABR_ST_NOISE    2
`define UABR_ST_FRAMING  3
`define UABR_ST_PARITY   4
`define UABR_ST_RXIDLE   5
`define UABR_ST_TXIDLE   6
`define UABR_ST_NINTH    7
// Reset values
`define UABR_RST_CTRL    10'h000
`define UABR_RST_BAUD    16'h0033
// Timing counts
`define UABR_OVS_LAST    4'hF
`define UABR_VOTE_A      4'h7
`define UABR_VOTE_B      4'h8
`define UABR_VOTE_C      4'h9
`define UABR_BRK_LAST    4'hC
`define UABR_FIFO_DEPTH  3'h4
`endif

/* File: design/uabr_rx_sampler.v */
`timescale 1ns/1ps
`default_nettype none
module uabr_rx_sampler (
  input  wire        clk,
  input  wire        rstn,
  input  wire        rx_pin,
  input  wire [15:0] baud_divisor,
  output reg         ovs_tick_ff,
  output reg         line_level_ff
);
  reg  [15:0] div_cnt_ff;
  reg         sync1_ff;
  reg         sync2_ff;
  reg         sync3_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Sixteen-times tick from the divisor
  always @(posedge clk) begin
    if (!rstn) begin
      div_cnt_ff  <= 16'h0000;
      ovs_tick_ff <= 1'b0;
    end else if (div_cnt_ff >= baud_divisor) begin
      div_cnt_ff  <= 16'h0000;
      ovs_tick_ff <= 1'b1;
    end else begin
      div_cnt_ff  <= div_cnt_ff + 16'h0001;
      ovs_tick_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; idle line is high after reset
  always @(posedge clk) begin
    if (!rstn) begin
      sync1_ff      <= 1'b1;
      sync2_ff      <= 1'b1;
      sync3_ff      <= 1'b1;
      line_level_ff <= 1'b1;
    end else begin
      sync1_ff <= rx_pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff) begin
        line_level_ff <= sync3_ff;
      end
    end
  end
endmodule // uabr_rx_sampler
`default_nettype wire

/* File: test/uabr_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uabr_consts.vh"
module uabr_top_props #(
  parameter int BIT_CLKS = 16
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        rx_pin,
  input wire logic        tx_pin_ff,
  input wire logic        rx_irq_ff
);
  localparam int BRK_CLKS = 13 * BIT_CLKS;
  localparam int IDLE_CLKS = 3 * BIT_CLKS;
  logic        ctl_wr_ff;
  logic        brk_ff;
  logic        rie_ff;
  logic [11:0] low_cnt_ff;
  logic [11:0] high_cnt_ff;
  logic [3:0]  hold_cnt_ff;
  ////////////////////////////////////////
  // Shadow of control writes; the checker sees only the bus
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctl_wr_ff   <= 1'b0;
      brk_ff      <= 1'b0;
      rie_ff      <= 1'b0;
      low_cnt_ff  <= 12'h000;
      high_cnt_ff <= 12'hfff;
      hold_cnt_ff <= 4'h0;
    end else begin
      ctl_wr_ff   <= hsel && htrans[1] && hready && hwrite && (haddr[7:0] == `UABR_OFS_CTRL);
      if (ctl_wr_ff) begin
        brk_ff <= hwdata[`UABR_CTL_BREAK];
        rie_ff <= hwdata[`UABR_CTL_RIE];
      end
      low_cnt_ff  <= tx_pin_ff ? 12'h000 : low_cnt_ff + 12'h001;
      high_cnt_ff <= !tx_pin_ff ? 12'h000 : (high_cnt_ff == 12'hfff ? high_cnt_ff : high_cnt_ff + 12'h001);
      hold_cnt_ff <= !brk_ff ? 4'h0 : (hold_cnt_ff == 4'hf ? hold_cnt_ff : hold_cnt_ff + 4'h1);
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_break_armed: assert property ($fell(tx_pin_ff) |-> hold_cnt_ff >= 4'h2)
    else $error("break began before the request was held long enough");
  chk_break_starts: assert property ((hold_cnt_ff == 4'h2 && high_cnt_ff >= IDLE_CLKS) |-> ##[0:40] !tx_pin_ff)
    else $error("break did not begin after request");
  chk_break_length: assert property ($rose(tx_pin_ff) |-> low_cnt_ff >= 14 * BIT_CLKS && low_cnt_ff % BRK_CLKS == BIT_CLKS)
    else $error("break low time not start plus 13N bits");
  chk_break_repeat: assert property ($rose(tx_pin_ff) |-> !brk_ff)
    else $error("break ended while still requested");
  chk_stop_after: assert property ($fell(tx_pin_ff) |-> high_cnt_ff >= BIT_CLKS)
    else $error("too little high time before a break");
  chk_irq_enabled: assert property (rx_irq_ff |-> rie_ff || $past(rie_ff))
    else $error("receive interrupt while disabled");
  chk_irq_pulse: assert property (rx_irq_ff |=> !rx_irq_ff)
    else $error("receive interrupt longer than one cycle");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered error");
  chk_rdata_idle: assert property (!$past(hsel && htrans[1] && hready && !hwrite) |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  cover property ($rose(tx_pin_ff));
  cover property (rx_irq_ff);
  cover property (hrdata != 32'h0000_0000);
endmodule // uabr_top_props
`default_nettype wire

/* File: test/uabr_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uabr_line_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk,
  input  wire logic tx_line,
  output var  logic rx_line
);
  int low_run = 0;
  int last_low = 0;
  int spike = -1;
  initial rx_line = 1'b1;
  // Whole bit times only; idle line is pulled high
  task automatic hold(input logic lvl, input int bits);
    rx_line <= lvl;
    repeat (bits * BIT_CLKS) @(posedge clk);
  endtask
  // High bit with a two-clock low spike that only the last vote sees
  task automatic spike_bit();
    rx_line <= 1'b1;
    repeat (10) @(posedge clk);
    rx_line <= 1'b0;
    repeat (2) @(posedge clk);
    rx_line <= 1'b1;
    repeat (BIT_CLKS - 12) @(posedge clk);
  endtask
  task automatic send(input logic [8:0] d, input int nb, input int par, input logic stp);
    hold(1'b0, 1);
    for (int i = 0; i < nb; i++) begin
      if (i == spike) spike_bit();
      else hold(d[i], 1);
    end
    if (par >= 0) hold(par[0], 1);
    hold(stp, 1);
    hold(1'b1, 3);
  endtask
  // Length of the last low run on the transmit line
  always @(posedge clk) begin
    if (tx_line === 1'b0) low_run <= low_run + 1;
    else if (low_run != 0) begin
      last_low <= low_run;
      low_run  <= 0;
    end
  end
endmodule // uabr_line_model
`default_nettype wire

/* File: test/uabr_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module uabr_tb_top;
  localparam int BIT_CLKS = 16;
  logic        clk = 1'b0;
  logic        rstn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        rx_line;
  logic        tx_pin_ff;
  logic        rx_irq_ff;
  logic [31:0] smp_rd;
  logic        smp_rdy;
  logic [31:0] rd;
  logic [8:0]  d;
  logic        bad;
  logic        pb;
  logic [8:0]  exp_q[$];
  logic        ovr_e = 1'b0;
  logic        fram_e = 1'b0;
  logic        par_e = 1'b0;
  logic        nse_e = 1'b0;
  int          trig = 1;
  int          err_total = 0;
  int          checks_done = 0;
  int          irq_seen = 0;
  int          irq_exp = 0;
  int          seed = 32'h4157_ba7d;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    smp_rd  <= hrdata;
    smp_rdy <= hreadyout;
  end
  always @(negedge clk) if (rx_irq_ff === 1'b1) irq_seen++;
  uabr_top u_uabr_top (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_pin(rx_line), .tx_pin_ff(tx_pin_ff), .rx_irq_ff(rx_irq_ff));
  uabr_line_model #(.BIT_CLKS(BIT_CLKS)) u_line (.clk(clk), .tx_line(tx_pin_ff), .rx_line(rx_line));
  ////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Waits on ready sampled at the edge; no fixed latency assumed
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do begin @(posedge clk); #1; end while (smp_rdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge clk); #1; end while (smp_rdy !== 1'b1);
    rd = smp_rd;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask
  task automatic cfg(input logic [31:0] v);
    xfer(1'b1, 8'h08, v);
    trig = int'(v[9:8]) + 1;
  endtask
  ////////////////////////////////////////
  // Bench model of the receive buffer and its sticky flags
  function automatic logic [31:0] stat_exp();
    return {24'h0, exp_q.size() != 0 ? exp_q[0][8] : 1'b0, 2'b11, par_e, fram_e, nse_e, ovr_e, exp_q.size() != 0};
  endfunction
  task automatic push(input logic [8:0] w, input logic f, input logic p);
    if (exp_q.size() < 4) begin
      exp_q.push_back(w);
      fram_e |= f;
      par_e  |= p;
      if (exp_q.size() == trig) irq_exp++;
    end else begin
      ovr_e = 1'b1;
      irq_exp++;
    end
  endtask
  task automatic pair();
    rd_chk(8'h00, stat_exp(), "status");
    rd_chk(8'h04, {23'h0, exp_q.pop_front()}, "data");
    ovr_e  = 1'b0;
    nse_e  = 1'b0;
    fram_e = 1'b0;
    par_e  = 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    rd_chk(8'h00, 32'h0000_0060, "status");
    rd_chk(8'h08, 32'h0000_0000, "ctrl");
    rd_chk(8'h0C, 32'h0000_0033, "baud");
    rd_chk(8'h10, 32'h0000_0000, "count");
    xfer(1'b1, 8'h14, 32'hffff_ffff);
    rd_chk(8'h14, 32'h0000_0000, "unmapped");
    xfer(1'b1, 8'h0C, 32'h0000_0000);
    // Receiver still off: the frame must be ignored
    u_line.send(9'h0a5, 8, -1, 1'b1);
    rd_chk(8'h10, 32'h0000_0000, "count");
    cfg(32'h0000_0381);
    // Short low spike on an idle line: start rejected at mid-bit
    u_line.spike_bit();
    u_line.hold(1'b1, 1);
    for (int i = 0; i < 5; i++) begin
      d = 9'($random(seed));
      d[8] = 1'b0;
      u_line.send(d, 8, -1, 1'b1);
      push(d, 1'b0, 1'b0);
      rd_chk(8'h10, 32'(exp_q.size()), "count");
    end
    check("irq", irq_exp, irq_seen);
    while (exp_q.size() != 0) pair();
    for (int t = 0; t < 4; t++) begin
      cfg(32'h0000_0087 | (t << 3));
      d = 9'($random(seed));
      bad = 1'($random(seed));
      pb = (t == 0) ? ^d : (t == 1) ? ~^d : (t == 2);
      u_line.send(d, 9, int'(pb ^ bad), 1'b1);
      push(d, 1'b0, bad);
      pair();
    end
    // One spiked vote in bit 0: word kept, noise flagged
    cfg(32'h0000_0081);
    d = 9'($random(seed));
    d[8] = 1'b0;
    d[0] = 1'b1;
    u_line.spike = 0;
    u_line.send(d, 8, -1, 1'b1);
    u_line.spike = -1;
    push(d, 1'b0, 1'b0);
    nse_e = 1'b1;
    pair();
    cfg(32'h0000_0081);
    d = 9'($random(seed));
    d[8] = 1'b0;
    u_line.send(d, 8, -1, 1'b0);
    push(d, 1'b1, 1'b0);
    u_line.hold(1'b0, 30);
    u_line.hold(1'b1, 3);
    push(9'h000, 1'b1, 1'b0);
    rd_chk(8'h10, 32'h0000_0002, "count");
    pair();
    pair();
    cfg(32'h0000_0060);
    repeat (20 * BIT_CLKS) @(posedge clk);
    rd_chk(8'h00, 32'h0000_0020, "status");
    cfg(32'h0000_0020);
    repeat (40 * BIT_CLKS) @(posedge clk);
    check("break length", 27 * BIT_CLKS, u_line.last_low);
    rd_chk(8'h00, 32'h0000_0060, "status");
    check("irq", irq_exp, irq_seen);
    test_done();
  end
  // Hang guard, well beyond the expected run
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    $display("BAD watchdog expected finish seen timeout");
    test_done();
  end
endmodule // uabr_tb_top
bind uabr_top uabr_top_props #(.BIT_CLKS(16)) u_uabr_top_props (.clk(clk), .rstn(rstn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_pin(rx_pin), .tx_pin_ff(tx_pin_ff),
  .rx_irq_ff(rx_irq_ff));
`default_nettype wire
